// ===== hdl/scsx_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module scsx_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_arst_n,
   // fill side
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   // drain side
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_r [D];
   logic [AW:0]  cnt_r;
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic         push;
   logic         pop;

   assign o_ready = (cnt_r != (AW+1)'(D));
   assign push    = i_valid & o_ready;
   assign pop     = (cnt_r != '0) & (~o_valid | i_ready);

   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem_r[wp_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // output stage is a register fed from the array
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_valid <= 1'b0;
         o_data  <= '0;
      end else if (pop) begin
         o_valid <= 1'b1;
         o_data  <= mem_r[rp_r];
      end else if (i_ready) begin
         o_valid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/scsx_pkg.sv
package scsx_pkg;

   // ****************************************
   // register field positions
   // ****************************************
   localparam int MC_PWR  = 7;
   localparam int MC_TXE  = 6;
   localparam int MC_RXE  = 5;
   localparam int MC_DIR  = 4;
   localparam int MC_TMS  = 1;
   localparam int MC_SCE  = 0;
   localparam int CS_CKP  = 4;
   localparam int CS_DAP  = 3;
   localparam int CS_CKS0 = 0;
   localparam int LS_CL0  = 0;

   // ****************************************
   // codes, widths, reset values
   // ****************************************
   localparam logic [2:0] CKS_EXT     = 3'h7;
   localparam logic [3:0] WL_8BIT     = 4'h0;
   localparam int         WORD_BITS   = 8;
   localparam int         FIFO_DEPTH  = 8;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   localparam logic [7:0] DATA_RST    = 8'h00;
   localparam logic [2:0] CNT_RST     = 3'h0;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_SHIFT
   } scsx_state_t;

   typedef struct packed {
      logic block_enable;
      logic tx_enable;
      logic rx_enable;
      logic bit_order;
      logic cont_mode;
      logic continue_enable;
      logic clock_polarity;
      logic data_phase;
      logic ext_clock;
      logic len_8bit;
   } scsx_mode_t;

endpackage

// ===== hdl/scsx_slave.sv
`timescale 1ns/1ns
`default_nettype none
// What the document asks of this block, its software and the master
// RL1 - software selects slave mode by writing 07H to clock_select_reg
// RL2 - decode: MSB first 0, type 1 is 00, clock 111 external, length 0000
// RL3 - software writes 00H to length_select_reg for 8-bit words
// RL4 - software writes A3H to mode_control_reg for continuous receive
// RL5 - software writes E3H to mode_control_reg for continuous transmit/receive
// RL6 - receive-only: dummy read of rx holding sets transfer-active, then wait
// RL7 - transmit/receive: tx holding write sets transfer-active, then wait for clock
// RL8 - master must not clock before the dummy read or transmit write
// RL9 - shift out and sample in, both on the external serial clock
// RL10 - word received: raise rx-done, word readable in rx holding
// RL11 - receive-only with continue-enable: further clocks start next word
// RL12 - continue-enable cleared: transfer-active drops when the word completes
// RL13 - continuous: tx-ready when holding moves into the shift register
// RL14 - transmit/receive: continue if new data written, else stop at word end
// RL15 - software checks transfer-active is 0 before clearing enables
// RL16 - next word before read: rx-done again and overrun set (the code sets overrun in continuous mode only)
// RL17 - on overrun the rx holding is overwritten
// RL18 - overrun if unread half a clock before the last bit sample
// RL19 - overrun in continuous mode ends the sequence
// RL20 - software clears overrun then reads rx holding
// RL21 - single mode: no tx-ready, rx-done at every end even transmit-only
// RL22 - single mode: tx write while active is ignored
// RL23 - software clears block enable and reinitialises after bad rewrites
// RL24 - overrun stays set until software clears it
module scsx_slave (
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_arst_n,
   // configuration registers
   input  wire logic [7:0] i_mode_control_reg,
   input  wire logic [7:0] i_clock_select_reg,
   input  wire logic [7:0] i_length_select_reg,
   // transmit holding write
   input  wire logic       i_tx_wr,
   input  wire logic [7:0] i_tx_data,
   // receive holding read
   input  wire logic       i_rx_rd,
   output logic            o_rx_rd_ok,
   output logic [7:0]      o_rx_holding_reg,
   // received word stream
   output logic            o_rx_valid,
   input  wire logic       i_rx_ready,
   output logic [7:0]      o_rx_data,
   // status and events
   input  wire logic       i_overrun_clr,
   output logic            o_transfer_active_flag,
   output logic            o_overrun_flag,
   output logic            o_rx_done_irq,
   output logic            o_tx_ready_irq,
   // serial pins
   input  wire logic       i_serial_clock_pin,
   input  wire logic       i_serial_in_pin,
   output logic            o_serial_out_pin
);

   // ****************************************
   // mode decode
   // ****************************************
   scsx_pkg::scsx_mode_t mode;
   logic                 en;

   always_comb begin
      mode.block_enable    = i_mode_control_reg[scsx_pkg::MC_PWR];
      mode.tx_enable       = i_mode_control_reg[scsx_pkg::MC_TXE];
      mode.rx_enable       = i_mode_control_reg[scsx_pkg::MC_RXE];
      mode.bit_order       = i_mode_control_reg[scsx_pkg::MC_DIR];
      mode.cont_mode       = i_mode_control_reg[scsx_pkg::MC_TMS];
      mode.continue_enable = i_mode_control_reg[scsx_pkg::MC_SCE];
      mode.clock_polarity  = i_clock_select_reg[scsx_pkg::CS_CKP];
      mode.data_phase      = i_clock_select_reg[scsx_pkg::CS_DAP];
      mode.ext_clock       = (i_clock_select_reg[scsx_pkg::CS_CKS0 +: 3]
                              == scsx_pkg::CKS_EXT); // RL2
      mode.len_8bit        = (i_length_select_reg[scsx_pkg::LS_CL0 +: 4]
                              == scsx_pkg::WL_8BIT); // RL2
   end

   // only the slave, 8-bit, data-phase-0 setup runs
   assign en = mode.block_enable & mode.ext_clock & mode.len_8bit & ~mode.data_phase;

   // ****************************************
   // pin synchronisers and clock edges
   // ****************************************
   logic sck_m_r;
   logic sck_s_r;
   logic sck_d_r;
   logic si_m_r;
   logic si_s_r;
   logic samp_ev;
   logic drv_ev;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sck_m_r <= 1'b1;
         sck_s_r <= 1'b1;
         sck_d_r <= 1'b1;
         si_m_r  <= 1'b0;
         si_s_r  <= 1'b0;
      end else begin
         sck_m_r <= i_serial_clock_pin;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r;
         si_m_r  <= i_serial_in_pin;
         si_s_r  <= si_m_r;
      end
   end

   // type 1: sample on the rising edge, drive on the falling edge
   assign samp_ev = mode.clock_polarity ? (~sck_s_r & sck_d_r) : (sck_s_r & ~sck_d_r); // RL9
   assign drv_ev  = mode.clock_polarity ? (sck_s_r & ~sck_d_r) : (~sck_s_r & sck_d_r); // RL9

   // ****************************************
   // transfer control
   // ****************************************
   scsx_pkg::scsx_state_t state_r;
   scsx_pkg::scsx_state_t state_nxt;
   logic [2:0] cnt_r;
   logic [7:0] tx_sh_r;
   logic [7:0] tx_hold_r;
   logic       tx_full_r;
   logic [7:0] rx_sh_r;
   logic [7:0] rx_word;
   logic       rx_unread_r;
   logic       ovr_arm_r;
   logic       run;
   logic       done;
   logic       rd_acc;
   logic       wr_take;
   logic       start_tx;
   logic       start_rx;
   logic       ovr_evt;
   logic       cont;
   logic       reload;
   logic       fifo_rdy;

   assign run      = (state_r != scsx_pkg::ST_IDLE);
   assign done     = run & samp_ev & (cnt_r == scsx_pkg::LAST_BIT);
   assign rd_acc   = i_rx_rd & fifo_rdy;
   assign wr_take  = i_tx_wr & en & mode.tx_enable & ~(~mode.cont_mode & run); // RL22
   assign start_tx = wr_take & ~run; // RL7
   assign start_rx = rd_acc & en & mode.rx_enable & ~mode.tx_enable & ~run; // RL6
   assign ovr_evt  = done & mode.rx_enable & mode.cont_mode & ovr_arm_r; // RL16 RL18
   assign rx_word  = mode.bit_order ? {si_s_r, rx_sh_r[7:1]} : {rx_sh_r[6:0], si_s_r};

   always_comb begin
      if (!mode.cont_mode || ovr_evt) begin
         cont = 1'b0; // RL19
      end else if (mode.tx_enable) begin
         cont = tx_full_r | wr_take; // RL14
      end else begin
         cont = mode.continue_enable; // RL11 RL12
      end
   end

   assign reload = done & cont & mode.tx_enable;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         scsx_pkg::ST_IDLE: begin
            if (start_tx || start_rx) begin
               state_nxt = scsx_pkg::ST_ARMED;
            end
         end
         scsx_pkg::ST_ARMED: begin
            if (samp_ev) begin
               state_nxt = scsx_pkg::ST_SHIFT;
            end
         end
         scsx_pkg::ST_SHIFT: begin
            if (done) begin
               state_nxt = cont ? scsx_pkg::ST_ARMED : scsx_pkg::ST_IDLE; // RL12 RL14
            end
         end
         default: begin
            state_nxt = scsx_pkg::ST_IDLE;
         end
      endcase
      if (!en) begin
         state_nxt = scsx_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= scsx_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= scsx_pkg::CNT_RST;
      end else if (!run || done) begin
         cnt_r <= scsx_pkg::CNT_RST;
      end else if (samp_ev) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // ****************************************
   // transmit path
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_hold_r <= scsx_pkg::DATA_RST;
         tx_full_r <= 1'b0;
      end else begin
         if (wr_take) begin
            tx_hold_r <= i_tx_data;
         end
         // a write landing on a reload of older held data keeps the holding full
         if (!en) begin
            tx_full_r <= 1'b0;
         end else if (wr_take && run && (tx_full_r || !reload)) begin
            tx_full_r <= 1'b1;
         end else if (reload) begin
            tx_full_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_sh_r <= scsx_pkg::DATA_RST;
      end else if (start_tx) begin
         tx_sh_r <= i_tx_data;
      end else if (reload) begin
         tx_sh_r <= tx_full_r ? tx_hold_r : i_tx_data; // RL13
      end else if (drv_ev && state_r == scsx_pkg::ST_SHIFT && cnt_r != scsx_pkg::CNT_RST) begin
         tx_sh_r <= mode.bit_order ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0}; // RL9
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_serial_out_pin <= 1'b0;
      end else if (en && mode.tx_enable) begin
         o_serial_out_pin <= mode.bit_order ? tx_sh_r[0] : tx_sh_r[7]; // RL9
      end else begin
         o_serial_out_pin <= 1'b0;
      end
   end

   // ****************************************
   // receive path
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_sh_r <= scsx_pkg::DATA_RST;
      end else if (run && samp_ev) begin
         rx_sh_r <= rx_word; // RL9
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_holding_reg <= scsx_pkg::DATA_RST;
      end else if (done && mode.rx_enable) begin
         o_rx_holding_reg <= rx_word; // RL10 RL17
      end
   end

   // set wins over a read in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_unread_r <= 1'b0;
      end else if (done && mode.rx_enable) begin
         rx_unread_r <= 1'b1;
      end else if (rd_acc) begin
         rx_unread_r <= 1'b0;
      end
   end

   // half a serial period before the last sample the read must be done
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ovr_arm_r <= 1'b0;
      end else if (!run || done) begin
         ovr_arm_r <= 1'b0;
      end else if (drv_ev && cnt_r == scsx_pkg::LAST_BIT) begin
         ovr_arm_r <= rx_unread_r & ~rd_acc; // RL18
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_overrun_flag <= 1'b0;
      end else if (ovr_evt) begin
         o_overrun_flag <= 1'b1; // RL16
      end else if (i_overrun_clr) begin
         o_overrun_flag <= 1'b0; // RL24
      end
   end

   // ****************************************
   // events and status
   // ****************************************
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_done_irq  <= 1'b0;
         o_tx_ready_irq <= 1'b0;
      end else begin
         o_rx_done_irq  <= done & (mode.rx_enable | ~mode.cont_mode); // RL10 RL21
         o_tx_ready_irq <= mode.cont_mode & (start_tx | reload); // RL13 RL21
      end
   end

   assign o_transfer_active_flag = run;

   // accepted reads hand the unread word to the stream buffer
   scsx_fifo #(
      .W (scsx_pkg::WORD_BITS),
      .D (scsx_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_valid   (i_rx_rd & rx_unread_r),
      .o_ready   (fifo_rdy),
      .i_data    (o_rx_holding_reg),
      .o_valid   (o_rx_valid),
      .i_ready   (i_rx_ready),
      .o_data    (o_rx_data)
   );

   assign o_rx_rd_ok = fifo_rdy;

   // ****************************************
   // checks
   // ****************************************
   property p_rx_start;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      start_rx |=> o_transfer_active_flag && state_r == scsx_pkg::ST_ARMED;
   endproperty
   a_rx_start: assert property (p_rx_start) else $error("dummy read did not arm"); // RL6

   property p_tx_start;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      start_tx |=> o_transfer_active_flag && tx_sh_r == $past(i_tx_data);
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("tx write did not arm"); // RL7

   property p_shift_msb;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (drv_ev && state_r == scsx_pkg::ST_SHIFT && cnt_r != 3'h0 && !mode.bit_order
       && !start_tx && !reload && en && mode.tx_enable)
      |=> tx_sh_r == {$past(tx_sh_r[6:0]), 1'b0} ##1 o_serial_out_pin == $past(tx_sh_r[7]);
   endproperty
   a_shift_msb: assert property (p_shift_msb) else $error("msb-first shift wrong"); // RL9

   property p_rx_done;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (done && mode.rx_enable) |=> o_rx_done_irq && o_rx_holding_reg == $past(rx_word);
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("word not delivered"); // RL10

   property p_rx_cont;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (done && en && mode.cont_mode && !mode.tx_enable && mode.continue_enable && !ovr_evt)
      |=> state_r == scsx_pkg::ST_ARMED;
   endproperty
   a_rx_cont: assert property (p_rx_cont) else $error("no continuation"); // RL11

   property p_rx_end;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (done && !mode.tx_enable && !mode.continue_enable) |=> !o_transfer_active_flag;
   endproperty
   a_rx_end: assert property (p_rx_end) else $error("active not cleared"); // RL12

   property p_tx_ready;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      o_tx_ready_irq |-> $past(mode.cont_mode) && $past(start_tx || reload);
   endproperty
   a_tx_ready: assert property (p_tx_ready) else $error("stray tx-ready"); // RL13 RL21

   property p_tx_stop;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (done && mode.tx_enable && !tx_full_r && !wr_take) |=> !o_transfer_active_flag;
   endproperty
   a_tx_stop: assert property (p_tx_stop) else $error("no stop without data"); // RL14

   property p_overrun;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      ovr_evt |=> o_overrun_flag && o_rx_done_irq && !o_transfer_active_flag;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun mishandled"); // RL16 RL19

   property p_ovr_hold;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (o_overrun_flag && !i_overrun_clr) |=> o_overrun_flag;
   endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost"); // RL24

   property p_single_ign;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      (i_tx_wr && !mode.cont_mode && run && !drv_ev) |=> $stable(tx_sh_r) && !tx_full_r;
   endproperty
   a_single_ign: assert property (p_single_ign) else $error("single write taken"); // RL22

endmodule
`default_nettype wire

// ===== verif/scsx_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module scsx_master_model (
   // serial pins
   output logic      o_serial_clock_pin,
   output logic      o_serial_in_pin,
   input  wire logic i_serial_out_pin
);
   // ****************************************
   // frame driver
   // ****************************************
   int half_ns = 160;

   initial begin
      o_serial_clock_pin = 1'b1;
      o_serial_in_pin    = 1'b0;
   end

   // clock stands high between frames; miso is read late in the high phase
   // so the slave's synchroniser delay is covered
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int k = 7; k >= 0; k--) begin
         o_serial_clock_pin = 1'b0;
         o_serial_in_pin    = d[k];
         #(half_ns);
         o_serial_clock_pin = 1'b1;
         #(half_ns * 3 / 4);
         q[k] = i_serial_out_pin;
         #(half_ns - half_ns * 3 / 4);
      end
      // released line shows the inverse of the last bit
      o_serial_in_pin = ~d[0];
   endtask
endmodule
`default_nettype wire

// ===== verif/scsx_slave_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module scsx_slave_tb;
   logic       clk;
   logic       arst_n;
   logic [7:0] mode;
   logic [7:0] csel;
   logic [7:0] lsel;
   logic       tx_wr;
   logic [7:0] tx_data;
   logic       rx_rd;
   logic       rd_ok;
   logic [7:0] hold;
   logic       rx_valid;
   logic       rx_ready;
   logic [7:0] rx_data;
   logic       ovr_clr;
   logic       active;
   logic       ovr;
   logic       rxd_irq;
   logic       txr_irq;
   logic       sck;
   logic       si;
   logic       so;
   int         fails;
   int         n_checks;
   int         n_rxd;
   int         n_txr;
   logic [7:0] q[$];
   logic [7:0] exp_w;
   logic [7:0] mtab[2] = '{8'he3, 8'hf3};

   scsx_slave scsx_slave_i (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_mode_control_reg(mode),
      .i_clock_select_reg(csel), .i_length_select_reg(lsel),
      .i_tx_wr(tx_wr), .i_tx_data(tx_data), .i_rx_rd(rx_rd),
      .o_rx_rd_ok(rd_ok), .o_rx_holding_reg(hold), .o_rx_valid(rx_valid),
      .i_rx_ready(rx_ready), .o_rx_data(rx_data), .i_overrun_clr(ovr_clr),
      .o_transfer_active_flag(active), .o_overrun_flag(ovr),
      .o_rx_done_irq(rxd_irq), .o_tx_ready_irq(txr_irq),
      .i_serial_clock_pin(sck), .i_serial_in_pin(si), .o_serial_out_pin(so)
   );

   scsx_master_model scsx_master_model_i (
      .o_serial_clock_pin(sck), .o_serial_in_pin(si), .i_serial_out_pin(so)
   );

   // ****************************************
   // clock and monitors
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rxd_irq === 1'b1) n_rxd++;
      if (txr_irq === 1'b1) n_txr++;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         exp_w = (q.size() > 0) ? q.pop_front() : 8'hxx;
         `CHK("stream", exp_w, rx_data)
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int k = 0; k < 8; k++) rev[k] = v[7-k];
   endfunction

   task automatic results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic cfg(input logic [7:0] m);
      mode = 8'h00;
      cyc(2);
      csel = 8'h07;
      lsel = 8'h00;
      mode = m;
      cyc(2);
   endtask

   task automatic wr(input logic [7:0] d);
      tx_data = d;
      tx_wr   = 1'b1;
      cyc(1);
      tx_wr   = 1'b0;
   endtask

   task automatic rd(input logic [7:0] e, input bit push);
      rx_rd = 1'b1;
      if (push && rd_ok === 1'b1) q.push_back(e);
      cyc(1);
      rx_rd = 1'b0;
   endtask

   // one frame from the master, then a bounded wait for rx-done
   task automatic word(input logic [7:0] d, input logic [7:0] e_so);
      logic [7:0] r;
      int         n0;
      n0 = n_rxd;
      scsx_master_model_i.xfer(d, r);
      `CHK("serial_out", e_so, r)
      for (int i = 0; i < 100 && n_rxd <= n0; i++) cyc(1);
      if (n_rxd <= n0) begin
         fails++;
         $display("BAD rx_done exp %0d got %0d", n0 + 1, n_rxd);
         results();
      end
      cyc(2);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      int         n0;
      int         n1;
      logic [7:0] e;
      {mode, csel, lsel, tx_data, tx_wr, rx_rd, ovr_clr} = '0;
      arst_n   = 1'b0;
      rx_ready = 1'b1;
      cyc(8);
      arst_n = 1'b1;
      cyc(1);
      `CHK("active_rst", 1'b0, active)
      `CHK("ovr_rst", 1'b0, ovr)
      // continuous receive, then stop by clearing continue
      cfg(8'ha3);
      rd(8'h00, 1'b0);
      cyc(1);
      `CHK("active_rx", 1'b1, active)
      word(8'ha5, 8'h00);
      `CHK("hold", 8'ha5, hold)
      `CHK("active_cont", 1'b1, active)
      rd(8'ha5, 1'b1);
      word(8'h3c, 8'h00);
      `CHK("hold", 8'h3c, hold)
      mode = 8'ha2;
      rd(8'h3c, 1'b1);
      word(8'h69, 8'h00);
      `CHK("active_stop", 1'b0, active)
      rd(8'h69, 1'b1);
      // overrun: second word lands unread
      cfg(8'ha3);
      rd(8'h00, 1'b0);
      word(8'h11, 8'h00);
      word(8'h22, 8'h00);
      `CHK("ovr_set", 1'b1, ovr)
      `CHK("hold_ovr", 8'h22, hold)
      `CHK("active_ovr", 1'b0, active)
      rd(8'h22, 1'b1);
      word(8'h33, 8'h00);
      `CHK("ovr_sticky", 1'b1, ovr)
      ovr_clr = 1'b1;
      cyc(1);
      ovr_clr = 1'b0;
      cyc(1);
      `CHK("ovr_clr", 1'b0, ovr)
      rd(8'h33, 1'b1);
      // continuous transmit/receive, both bit orders
      foreach (mtab[i]) begin
         cfg(mtab[i]);
         n0 = n_txr;
         `CHK("active_idle", 1'b0, active)
         wr(8'h96);
         cyc(1);
         `CHK("active_tx", 1'b1, active)
         `CHK("tx_ready1", n0 + 1, n_txr)
         wr(8'h5a);
         word(8'hc3, mtab[i][4] ? rev(8'h96) : 8'h96);
         e = mtab[i][4] ? rev(8'hc3) : 8'hc3;
         `CHK("hold_tx", e, hold)
         `CHK("tx_ready2", n0 + 2, n_txr)
         `CHK("active_more", 1'b1, active)
         rd(e, 1'b1);
         word(8'h81, mtab[i][4] ? rev(8'h5a) : 8'h5a);
         `CHK("active_end", 1'b0, active)
         rd(mtab[i][4] ? rev(8'h81) : 8'h81, 1'b1);
      end
      // single mode, transmit-only then transmit/receive
      for (int k = 0; k < 2; k++) begin
         cfg(k ? 8'he0 : 8'hc0);
         n0 = n_txr;
         n1 = n_rxd;
         wr(8'h42);
         cyc(1);
         wr(8'h99);
         word(8'h0f, 8'h42);
         `CHK("no_tx_ready", n0, n_txr)
         `CHK("rx_done_single", n1 + 1, n_rxd)
         `CHK("active_single", 1'b0, active)
         if (k == 1) rd(8'h0f, 1'b1);
      end
      // stream buffer: fill with far side stalled, then drain
      cfg(8'ha3);
      rx_ready = 1'b0;
      rd(8'h00, 1'b0);
      for (int k = 0; k < 12; k++) begin
         e = 8'hd0 + 8'(k);
         word(e, 8'h00);
         if (rd_ok !== 1'b1) break;
         rd(e, 1'b1);
      end
      `CHK("fifo_full", 1'b0, rd_ok)
      rd(e, 1'b1);
      rx_ready = 1'b1;
      for (int i = 0; i < 200 && q.size() > 0; i++) cyc(1);
      if (q.size() > 0) begin
         fails++;
         $display("BAD drain exp %0d got %0d", 0, q.size());
         results();
      end
      cyc(3);
      `CHK("fifo_empty", 1'b0, rx_valid)
      `CHK("fifo_ok", 1'b1, rd_ok)
      rd(e, 1'b1);
      cyc(10);
      `CHK("fifo_drained", 0, q.size())
      results();
   end
endmodule
`default_nettype wire
